// ### pkg/cpu_decode_params.svh
// Purpose: Constants for the opcode decode and timing block
// Assumes: 8-bit opcodes, cycle counts at the core clock
// Notes: High nibble selects the group or addressing mode
`ifndef CPU_DECODE_PARAMS_SVH
`define CPU_DECODE_PARAMS_SVH

// Opcode high nibble: group or addressing mode
`define HI_BIT_TEST 4'h0
`define HI_BIT_SETCLR 4'h1
`define HI_REL 4'h2
`define HI_INH_ACC 4'h4
`define HI_INH_IDX 4'h5
`define HI_CTRL_LO 4'h8
`define HI_CTRL_HI 4'h9
`define HI_IMM 4'hA
`define HI_DIR 4'hB
`define HI_EXT 4'hC
`define HI_IX16 4'hD
`define HI_IX8 4'hE
`define HI_IX0 4'hF

// Whole opcodes with their own timing or checks
`define OPC_BRANCH_SUB 8'hAD
`define OPC_MULTIPLY 8'h42
`define OPC_RET_INT 8'h80
`define OPC_RET_SUB 8'h81
`define OPC_SOFT_INT 8'h83
`define OPC_BR_HIGHER 8'h22
`define OPC_BR_CARRY_CLR 8'h24
`define OPC_BR_HALF_SET 8'h29
`define OPC_BR_MASK_SET 8'h2D
`define OPC_BR_IRQ_LOW 8'h2E

// Instruction lengths in bytes
`define LEN_1 2'h1
`define LEN_2 2'h2
`define LEN_3 2'h3

// Cycle counts, memory operations by mode
`define CYC_IMM 4'h2
`define CYC_DIR 4'h3
`define CYC_EXT 4'h4
`define CYC_IX0 4'h3
`define CYC_IX8 4'h4
`define CYC_IX16 4'h5
`define CYC_STORE_ADD 4'h1
`define CYC_JUMP_SUB 4'h1
`define CYC_CALL_ADD 4'h2

// Cycle counts, other groups
`define CYC_REL 4'h3
`define CYC_REL_CALL 4'h6
`define CYC_BIT 4'h5
`define CYC_INH 4'h3
`define CYC_CTRL 4'h2
`define CYC_MUL 4'hB
`define CYC_RTI 4'h9
`define CYC_RTS 4'h6
`define CYC_SWI 4'hA
`define CYC_UNSUP 4'h2

// Fetch plus decode cycles, and the wait count offset
`define CYC_FETCH_DECODE 4'h2
`define CYC_TO_EXEC 4'h3

`endif

// ### pkg/cpu_decode_pkg.sv
// Purpose: Types for the opcode decode and timing block
// Assumes: Memory operations listed in low-nibble order
// Notes: First sixteen operations cast straight from the low nibble
package cpu_decode_pkg;

    typedef enum logic [4:0] {
        op_subtract, op_compare_accumulator, op_subtract_with_borrow,
        op_compare_index, op_and, op_bit_test, op_load_accumulator,
        op_store_accumulator, op_exclusive_or_memory, op_add_with_carry,
        op_or_memory, op_add, op_jump_unconditional, op_jump_subroutine,
        op_load_index_register, op_store_index_register,
        op_branch_relative, op_branch_subroutine, op_test_bit_branch_set,
        op_test_bit_branch_clear, op_set_direct_bit, op_clear_direct_bit,
        op_inherent, op_unsupported
    } op_t;

    typedef enum logic [3:0] {
        mode_inherent, mode_immediate, mode_direct, mode_extended,
        mode_indexed0, mode_indexed8, mode_indexed16, mode_relative,
        mode_bit_setclr, mode_bit_test
    } mode_t;

    typedef enum logic [1:0] {
        st_start, st_fetch, st_decode, st_exec
    } state_t;

endpackage

// ### hw/cpu_opcode_decode_timing.sv
// Purpose: Fetch opcodes, decode operation, length and cycle count
// Assumes: Fetch data valid the cycle after bus_rd_o
// Notes: Next fetch issued once the instruction's cycles elapse
`timescale 1ns/1ps
`include "cpu_decode_params.svh"

// What this block does
// - Inherent opcodes decode alone, one byte
// - Immediate operand at next address, counter plus two
// - Add with carry opcodes, mode timings
// - Subtract with borrow opcode family
// - Exclusive or opcode family
// - Compare sets flags, accumulator untouched
// - Bit test ands without storing
// - Higher and lower-or-same branches, three cycles
// - Carry clear and carry set branches
// - Half carry clear and set branches
// - Interrupt mask clear and set branches
// - Interrupt line low and high branches
// - Branch to subroutine, six cycles, saves return
// - Bit set test branch, three bytes, five cycles
// - Bit clear test branch, three bytes, five cycles
// - Set or clear direct bit, five cycles
module cpu_opcode_decode_timing #(
    parameter int ADDR_W = 16,
    parameter logic [15:0] RESET_ADDR = 16'h0000
) (
    input logic clk_i,
    input logic rst_i,
    input logic [7:0] bus_data_i,
    input logic carry_i,
    input logic zero_i,
    input logic negative_i,
    input logic half_carry_i,
    input logic int_mask_i,
    input logic irq_line_i,
    output logic [ADDR_W-1:0] bus_addr_o,
    output logic bus_rd_o,
    output logic [ADDR_W-1:0] prog_counter_o,
    output logic instr_valid_o,
    output logic [7:0] opcode_o,
    output cpu_decode_pkg::op_t op_o,
    output cpu_decode_pkg::mode_t mode_o,
    output logic [1:0] len_o,
    output logic [3:0] cycles_o,
    output logic [ADDR_W-1:0] eff_addr_o,
    output logic eff_addr_valid_o,
    output logic branch_taken_o,
    output logic [2:0] bit_num_o,
    output logic [7:0] bit_mask_o,
    output logic writes_acc_o,
    output logic save_return_o,
    output logic unsupported_o
);
    import cpu_decode_pkg::*;

    state_t state_reg;
    state_t state_next;
    logic [ADDR_W-1:0] iptr_reg;
    logic [ADDR_W-1:0] iptr_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic [3:0] count_reg;
    logic [3:0] count_next;
    logic rd_reg;
    logic decoding;

    logic [7:0] opc;
    logic [3:0] hi;
    logic [3:0] lo;
    logic is_mem, is_btb, is_bsc, is_rel, is_inh, is_ctl, is_call;
    op_t mem_raw;
    logic no_imm, mem_bad, mem_good;
    mode_t mem_mode;
    logic [3:0] mem_base, mem_cyc, ctl_cyc;
    logic [1:0] mem_len;
    op_t dec_op;
    mode_t dec_mode;
    logic [1:0] dec_len;
    logic [3:0] dec_cyc;
    logic [7:0] cond_vec;
    logic rel_taken, dec_taken, dec_acc, dec_save, short_instr;
    logic [7:0] dec_mask;

    // Opcode fields and group flags
    assign opc = bus_data_i;
    assign hi = opc[7:4];
    assign lo = opc[3:0];
    assign is_mem = (hi >= `HI_IMM);
    assign is_btb = (hi == `HI_BIT_TEST);
    assign is_bsc = (hi == `HI_BIT_SETCLR);
    assign is_rel = (hi == `HI_REL);
    assign is_inh = (hi == `HI_INH_ACC) || (hi == `HI_INH_IDX);
    assign is_ctl = (hi == `HI_CTRL_LO) || (hi == `HI_CTRL_HI);
    assign is_call = (opc == `OPC_BRANCH_SUB);

    // Memory operation from low nibble, mode from high nibble
    assign mem_raw = op_t'({1'b0, lo});
    assign no_imm = (mem_raw == op_store_accumulator) ||
                    (mem_raw == op_store_index_register) ||
                    (mem_raw == op_jump_unconditional) ||
                    (mem_raw == op_jump_subroutine);
    assign mem_bad = is_mem && (hi == `HI_IMM) && no_imm && !is_call;
    assign mem_good = is_mem && !mem_bad && !is_call;
    assign mem_mode = (hi == `HI_IMM) ? mode_immediate :
                      (hi == `HI_DIR) ? mode_direct :
                      (hi == `HI_EXT) ? mode_extended :
                      (hi == `HI_IX16) ? mode_indexed16 :
                      (hi == `HI_IX8) ? mode_indexed8 : mode_indexed0;

    // Base timing and length per addressing mode
    assign mem_base = (mem_mode == mode_immediate) ? `CYC_IMM :
                      (mem_mode == mode_direct) ? `CYC_DIR :
                      (mem_mode == mode_extended) ? `CYC_EXT :
                      (mem_mode == mode_indexed16) ? `CYC_IX16 :
                      (mem_mode == mode_indexed8) ? `CYC_IX8 : `CYC_IX0;
    assign mem_len = (mem_mode == mode_indexed0) ? `LEN_1 :
                     (mem_mode == mode_extended ||
                      mem_mode == mode_indexed16) ? `LEN_3 : `LEN_2;

    // Stores, jumps and subroutine calls adjust the base timing
    assign mem_cyc = (mem_raw == op_store_accumulator ||
                      mem_raw == op_store_index_register) ?
                     mem_base + `CYC_STORE_ADD :
                     (mem_raw == op_jump_unconditional) ?
                     mem_base - `CYC_JUMP_SUB :
                     (mem_raw == op_jump_subroutine) ?
                     mem_base + `CYC_CALL_ADD : mem_base;

    // Control instruction timing
    assign ctl_cyc = (opc == `OPC_RET_INT) ? `CYC_RTI :
                     (opc == `OPC_RET_SUB) ? `CYC_RTS :
                     (opc == `OPC_SOFT_INT) ? `CYC_SWI : `CYC_CTRL;

    // Group selection of operation, mode, length and cycles
    assign dec_op = is_call ? op_branch_subroutine :
                    mem_bad ? op_unsupported :
                    is_mem ? mem_raw :
                    is_btb ? (lo[0] ? op_test_bit_branch_clear :
                              op_test_bit_branch_set) :
                    is_bsc ? (lo[0] ? op_clear_direct_bit :
                              op_set_direct_bit) :
                    is_rel ? op_branch_relative :
                    (is_inh || is_ctl) ? op_inherent : op_unsupported;
    assign dec_mode = (is_call || is_rel) ? mode_relative :
                      mem_good ? mem_mode :
                      is_btb ? mode_bit_test :
                      is_bsc ? mode_bit_setclr : mode_inherent;
    assign dec_len = is_call ? `LEN_2 :
                     mem_good ? mem_len :
                     is_btb ? `LEN_3 :
                     (is_bsc || is_rel) ? `LEN_2 : `LEN_1;
    assign dec_cyc = is_call ? `CYC_REL_CALL :
                     mem_good ? mem_cyc :
                     (is_btb || is_bsc) ? `CYC_BIT :
                     is_rel ? `CYC_REL :
                     is_inh ? ((opc == `OPC_MULTIPLY) ? `CYC_MUL : `CYC_INH) :
                     is_ctl ? ctl_cyc : `CYC_UNSUP;

    // Branch condition, pair chosen by bits 3:1, sense by bit 0
    assign cond_vec = {irq_line_i, int_mask_i, negative_i, half_carry_i,
                       zero_i, carry_i, carry_i | zero_i, 1'b0};
    assign rel_taken = lo[0] ? cond_vec[lo[3:1]] :
                       !cond_vec[lo[3:1]];
    assign dec_taken = is_rel ? rel_taken : is_call;

    // Only result-storing operations write the accumulator
    assign dec_acc = mem_good && (mem_raw == op_subtract ||
                     mem_raw == op_subtract_with_borrow ||
                     mem_raw == op_and || mem_raw == op_load_accumulator ||
                     mem_raw == op_exclusive_or_memory ||
                     mem_raw == op_add_with_carry ||
                     mem_raw == op_or_memory || mem_raw == op_add);
    assign dec_save = is_call ||
                      (mem_good && mem_raw == op_jump_subroutine);

    // Bit mask of the selected bit number
    generate
        for (genvar g = 0; g < 8; g++) begin : g_mask
            assign dec_mask[g] = (lo[3:1] == 3'(g));
        end
    endgenerate

    // Sequencer: fetch, decode, then wait out the instruction cycles
    assign decoding = (state_reg == st_decode);
    assign short_instr = (dec_cyc <= `CYC_FETCH_DECODE);
    assign state_next = (state_reg == st_start) ? st_fetch :
                        (state_reg == st_fetch) ? st_decode :
                        decoding ? (short_instr ? st_fetch : st_exec) :
                        (count_reg == 4'h0) ? st_fetch : st_exec;
    assign count_next = decoding ? dec_cyc - `CYC_TO_EXEC :
                        count_reg - 4'h1;
    assign iptr_next = decoding ? iptr_reg + ADDR_W'(dec_len) : iptr_reg;
    assign addr_next = (state_next == st_fetch) ? iptr_next : addr_reg;

    // Sequencer state and fetch address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= st_start;
            iptr_reg <= ADDR_W'(RESET_ADDR);
            addr_reg <= ADDR_W'(RESET_ADDR);
            count_reg <= 4'h0;
            rd_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            iptr_reg <= iptr_next;
            addr_reg <= addr_next;
            count_reg <= count_next;
            rd_reg <= (state_next == st_fetch);
        end
    end

    // Decoded fields, captured in the decode cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            instr_valid_o <= 1'b0;
            opcode_o <= 8'h00;
            op_o <= op_unsupported;
            mode_o <= mode_inherent;
            len_o <= `LEN_1;
            cycles_o <= `CYC_UNSUP;
            eff_addr_o <= '0;
            eff_addr_valid_o <= 1'b0;
            branch_taken_o <= 1'b0;
            bit_num_o <= 3'h0;
            bit_mask_o <= 8'h00;
            writes_acc_o <= 1'b0;
            save_return_o <= 1'b0;
            unsupported_o <= 1'b0;
        end else begin
            instr_valid_o <= decoding;
            if (decoding) begin
                opcode_o <= opc;
                op_o <= dec_op;
                mode_o <= dec_mode;
                len_o <= dec_len;
                cycles_o <= dec_cyc;
                eff_addr_o <= iptr_reg + ADDR_W'(1);
                eff_addr_valid_o <= (dec_mode == mode_immediate);
                branch_taken_o <= dec_taken;
                bit_num_o <= lo[3:1];
                bit_mask_o <= dec_mask;
                writes_acc_o <= dec_acc;
                save_return_o <= dec_save;
                unsupported_o <= (dec_op == op_unsupported);
            end
        end
    end

    assign bus_addr_o = addr_reg;
    assign bus_rd_o = rd_reg;
    assign prog_counter_o = iptr_reg;

    // Cycles from one fetch to the next, for the timing checks
    logic [3:0] span_reg;
    logic seen_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            span_reg <= 4'h0;
            seen_reg <= 1'b0;
        end else begin
            span_reg <= rd_reg ? 4'h1 : span_reg + 4'h1;
            seen_reg <= seen_reg | instr_valid_o;
        end
    end

    // Inherent instructions are one byte
    property p_inh_len;
        @(posedge clk_i) disable iff (rst_i)
        instr_valid_o && op_o == op_inherent |-> len_o == `LEN_1;
    endproperty
    a_inh_len: assert property (p_inh_len) else $error("inherent length");

    // Immediate operand address and counter advance
    property p_imm;
        @(posedge clk_i) disable iff (rst_i)
        instr_valid_o && mode_o == mode_immediate |->
            eff_addr_valid_o && eff_addr_o == $past(prog_counter_o) + 1 &&
            prog_counter_o == $past(prog_counter_o) + 2;
    endproperty
    a_imm: assert property (p_imm) else $error("immediate address");

    // Fetch spacing matches the decoded cycle count
    property p_span;
        @(posedge clk_i) disable iff (rst_i)
        bus_rd_o && seen_reg |-> span_reg == cycles_o;
    endproperty
    a_span: assert property (p_span) else $error("fetch spacing");

    // Add with carry timing per mode
    property p_adc;
        @(posedge clk_i) disable iff (rst_i)
        instr_valid_o && op_o == op_add_with_carry |->
            (mode_o == mode_immediate && cycles_o == 4'h2) ||
            (mode_o == mode_direct && cycles_o == 4'h3) ||
            (mode_o == mode_extended && cycles_o == 4'h4) ||
            (mode_o == mode_indexed0 && cycles_o == 4'h3) ||
            (mode_o == mode_indexed8 && cycles_o == 4'h4) ||
            (mode_o == mode_indexed16 && cycles_o == 4'h5);
    endproperty
    a_adc: assert property (p_adc) else $error("add carry timing");

    // Subtract with borrow family
    property p_borrow;
        @(posedge clk_i) disable iff (rst_i)
        instr_valid_o && opcode_o[3:0] == 4'h2 && opcode_o[7:4] >= 4'hA |->
            op_o == op_subtract_with_borrow && writes_acc_o;
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow decode");

    // Exclusive or family
    property p_xor;
        @(posedge clk_i) disable iff (rst_i)
        instr_valid_o && opcode_o[3:0] == 4'h8 && opcode_o[7:4] >= 4'hA |->
            op_o == op_exclusive_or_memory;
    endproperty
    a_xor: assert property (p_xor) else $error("xor decode");

    // Compare and bit test leave the accumulator alone
    property p_no_store;
        @(posedge clk_i) disable iff (rst_i)
        instr_valid_o && (op_o == op_compare_accumulator ||
                          op_o == op_bit_test) |-> !writes_acc_o;
    endproperty
    a_no_store: assert property (p_no_store) else $error("acc written");

    // Higher branch follows carry and zero at decode
    property p_higher;
        @(posedge clk_i) disable iff (rst_i)
        instr_valid_o && opcode_o == `OPC_BR_HIGHER |->
            branch_taken_o == !($past(carry_i) || $past(zero_i)) &&
            len_o == `LEN_2 && cycles_o == `CYC_REL;
    endproperty
    a_higher: assert property (p_higher) else $error("higher branch");

    // Carry clear branch
    property p_carry;
        @(posedge clk_i) disable iff (rst_i)
        instr_valid_o && opcode_o == `OPC_BR_CARRY_CLR |->
            branch_taken_o == !$past(carry_i);
    endproperty
    a_carry: assert property (p_carry) else $error("carry branch");

    // Half carry set and mask set branches
    property p_half_mask;
        @(posedge clk_i) disable iff (rst_i)
        instr_valid_o && (opcode_o == `OPC_BR_HALF_SET ||
                          opcode_o == `OPC_BR_MASK_SET) |->
            branch_taken_o == (opcode_o[2] ? $past(int_mask_i) :
                               $past(half_carry_i));
    endproperty
    a_half_mask: assert property (p_half_mask) else $error("flag branch");

    // Interrupt line low branch samples the pin
    property p_irq;
        @(posedge clk_i) disable iff (rst_i)
        instr_valid_o && opcode_o == `OPC_BR_IRQ_LOW |->
            branch_taken_o == !$past(irq_line_i);
    endproperty
    a_irq: assert property (p_irq) else $error("irq branch");

    // Branch to subroutine saves return, counter at return address
    property p_rel_call;
        @(posedge clk_i) disable iff (rst_i)
        instr_valid_o && opcode_o == `OPC_BRANCH_SUB |->
            save_return_o && cycles_o == `CYC_REL_CALL &&
            prog_counter_o == $past(prog_counter_o) + 2;
    endproperty
    a_rel_call: assert property (p_rel_call) else $error("subroutine branch");

    // Bit test branches, sense from bit 0
    property p_btb;
        @(posedge clk_i) disable iff (rst_i)
        instr_valid_o && opcode_o[7:4] == `HI_BIT_TEST |->
            len_o == `LEN_3 && cycles_o == `CYC_BIT &&
            bit_num_o == opcode_o[3:1] &&
            op_o == (opcode_o[0] ? op_test_bit_branch_clear :
                     op_test_bit_branch_set);
    endproperty
    a_btb: assert property (p_btb) else $error("bit branch");

    // Direct bit set and clear
    property p_bsc;
        @(posedge clk_i) disable iff (rst_i)
        instr_valid_o && opcode_o[7:4] == `HI_BIT_SETCLR |->
            len_o == `LEN_2 && cycles_o == `CYC_BIT &&
            bit_mask_o == (8'h01 << opcode_o[3:1]);
    endproperty
    a_bsc: assert property (p_bsc) else $error("bit set clear");

    // Stores have no immediate form and take a cycle more
    property p_store;
        @(posedge clk_i) disable iff (rst_i)
        instr_valid_o && (op_o == op_store_accumulator ||
                          op_o == op_store_index_register) |->
            mode_o != mode_immediate &&
            (mode_o != mode_direct || cycles_o == 4'h4);
    endproperty
    a_store: assert property (p_store) else $error("store timing");

    // Jumps have no immediate form
    property p_jump;
        @(posedge clk_i) disable iff (rst_i)
        instr_valid_o && (op_o == op_jump_unconditional ||
                          op_o == op_jump_subroutine) |->
            mode_o != mode_immediate;
    endproperty
    a_jump: assert property (p_jump) else $error("jump mode");

    // All relative branches are two bytes, three cycles
    property p_rel;
        @(posedge clk_i) disable iff (rst_i)
        instr_valid_o && op_o == op_branch_relative |->
            len_o == `LEN_2 && cycles_o == `CYC_REL;
    endproperty
    a_rel: assert property (p_rel) else $error("relative timing");

endmodule

// ### test/prog_mem_model.sv
// Purpose: Program memory answering opcode fetches of the decoder
// Assumes: Opcode expected on the bus the cycle after the fetch strobe
// Notes: Outside the answer cycle the bus shows the inverse of its last value
`timescale 1ns/1ps
module prog_mem_model (
    input wire logic clk_i,
    input wire logic rd_i,
    input wire logic [15:0] addr_i,
    output logic [7:0] data_o
);
    logic [7:0] mem [0:65535];

    // Answer a fetch for one cycle, otherwise scramble the released bus
    always_ff @(posedge clk_i) begin
        data_o <= rd_i ? mem[addr_i] : ~data_o;
    end
endmodule

// ### test/cpu_opcode_decode_timing_tb.sv
// Purpose: Self-checking bench for opcode decode, length and timing
// Assumes: Opcode placed in memory before its fetch is answered
// Notes: Fetch spacing checked against the previous cycle count
`timescale 1ns/1ps
module cpu_opcode_decode_timing_tb;
    import cpu_decode_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [5:0] flg = 6'h00;
    logic [7:0] bus_data, opcode, mask;
    logic [15:0] bus_addr, iptr_o, eff_addr;
    logic [2:0] bnum;
    mode_t mode;
    logic bus_rd, instr_valid, eff_valid, taken, wr_acc, save_ret, unsup;
    logic [1:0] len;
    logic [3:0] cycles;
    op_t op;
    logic [15:0] iptr = 16'h0000;
    logic [3:0] prev_cyc = 4'h0;
    int fail_count = 0;
    int comparisons = 0;
    int clk_count = 0;

    cpu_opcode_decode_timing dut (.clk_i(clk_i), .rst_i(rst_i), .bus_data_i(bus_data),
        .carry_i(flg[0]), .zero_i(flg[1]), .negative_i(flg[2]), .half_carry_i(flg[3]),
        .int_mask_i(flg[4]), .irq_line_i(flg[5]), .bus_addr_o(bus_addr), .bus_rd_o(bus_rd),
        .prog_counter_o(iptr_o), .instr_valid_o(instr_valid), .opcode_o(opcode), .op_o(op),
        .mode_o(mode), .len_o(len), .cycles_o(cycles), .eff_addr_o(eff_addr),
        .eff_addr_valid_o(eff_valid), .branch_taken_o(taken), .bit_num_o(bnum),
        .bit_mask_o(mask), .writes_acc_o(wr_acc), .save_return_o(save_ret),
        .unsupported_o(unsup));
    prog_mem_model mem_u (.clk_i(clk_i), .rd_i(bus_rd), .addr_i(bus_addr), .data_o(bus_data));

    // Clock and hang guard
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        clk_count++;
        if (clk_count == 3000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (fail_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Place one opcode, await its decode, compare all fields but mode, bit mask, bit number and accumulator write
    task automatic exec(input logic [7:0] opc, input op_t eop, input logic [1:0] ln,
        input logic [3:0] cyc, input logic tk, input logic imm);
        int n;
        n = 0;
        mem_u.mem[iptr] = opc;
        do begin
            @(posedge clk_i);
            #2;
            n++;
        end while (instr_valid !== 1'b1 && n < 16);
        if (prev_cyc != 4'h0) check(16'(n), 16'(prev_cyc), "fetch spacing");
        check(16'(opcode), 16'(opc), "opcode");
        check(16'(op), 16'(eop), "operation");
        check(16'(len), 16'(ln), "length");
        check(16'(cycles), 16'(cyc), "cycles");
        check(iptr_o, iptr + 16'(ln), "counter advance");
        check(16'(taken), 16'(tk), "branch taken");
        check(16'(save_ret), 16'(opc == 8'hAD || (opc[7:4] > 4'hA && opc[3:0] == 4'hD)), "save");
        check(16'(unsup), 16'(eop == op_unsupported), "unsupported");
        if (imm) check(eff_addr, iptr + 16'h0001, "operand address");
        check(16'(eff_valid), 16'(imm), "operand address valid");
        iptr = iptr + 16'(ln);
        prev_cyc = cyc;
    endtask

    // Inherent and control codes, then unsupported codes: one outside the decoded groups, immediate store and jump
    task automatic run_inherent();
        logic [11:0] tbl [8] = '{12'h42B, 12'h4C3, 12'h5F3, 12'h972, 12'h9D2, 12'h809,
            12'h816, 12'h83A};
        foreach (tbl[i]) exec(tbl[i][11:4], op_inherent, 2'h1, tbl[i][3:0], 1'b0, 1'b0);
        exec(8'h3C, op_unsupported, 2'h1, 4'h2, 1'b0, 1'b0);
        exec(8'hA7, op_unsupported, 2'h1, 4'h2, 1'b0, 1'b0);
        exec(8'hAC, op_unsupported, 2'h1, 4'h2, 1'b0, 1'b0);
    endtask

    // Every register/memory code in every addressing mode
    task automatic run_mem_ops();
        logic [3:0] cyc;
        logic [1:0] ln;
        op_t eop;
        for (int h = 10; h < 16; h++) begin
            for (int l = 0; l < 16; l++) begin
                if (h == 10 && (l == 7 || l == 12 || l == 13 || l == 15)) continue;
                eop = op_t'(5'(l));
                ln = (h == 12 || h == 13) ? 2'h3 : (h == 15) ? 2'h1 : 2'h2;
                cyc = 4'((h == 10) ? 2 : (h == 11 || h == 15) ? 3 : (h == 13) ? 5 : 4);
                cyc = cyc + ((l == 7 || l == 15) ? 4'h1 : (l == 13) ? 4'h2 : 4'h0);
                cyc = cyc - ((l == 12) ? 4'h1 : 4'h0);
                exec({4'(h), 4'(l)}, eop, ln, cyc, 1'b0, h == 10);
                check(16'(wr_acc), 16'(eop inside {op_subtract, op_subtract_with_borrow, op_and,
                    op_load_accumulator, op_exclusive_or_memory, op_add_with_carry,
                    op_or_memory, op_add}), "accumulator write");
                check(16'(mode), 16'((h == 10) ? mode_immediate : (h == 11) ? mode_direct :
                    (h == 12) ? mode_extended : (h == 13) ? mode_indexed16 :
                    (h == 14) ? mode_indexed8 : mode_indexed0), "mode");
            end
        end
    endtask

    // All relative branches under four flag patterns, then branch to subroutine
    task automatic run_branches();
        logic [7:0] cond;
        for (int p = 0; p < 4; p++) begin
            flg = (p == 0) ? 6'h00 : (p == 1) ? 6'h3F : (p == 2) ? 6'h15 : 6'h2A;
            cond = {~flg[5], ~flg[4], ~flg[2], ~flg[3], ~flg[1], ~flg[0], ~(flg[0] | flg[1]), 1'b1};
            for (int l = 0; l < 16; l++) begin
                exec(8'h20 + 8'(l), op_branch_relative, 2'h2, 4'h3, cond[l / 2] ^ l[0], 1'b0);
            end
        end
        exec(8'hAD, op_branch_subroutine, 2'h2, 4'h6, 1'b1, 1'b0);
    endtask

    // Bit test-and-branch and direct bit set/clear for every bit number
    task automatic run_bit_ops();
        for (int c = 0; c < 32; c++) begin
            exec(8'(c), (c < 16) ? (c[0] ? op_test_bit_branch_clear : op_test_bit_branch_set)
                : (c[0] ? op_clear_direct_bit : op_set_direct_bit),
                (c < 16) ? 2'h3 : 2'h2, 4'h5, 1'b0, 1'b0);
            check(16'(mask), 16'(8'h01 << c[3:1]), "bit mask");
            check(16'(bnum), 16'(c[3:1]), "bit number");
        end
    endtask

    // Reset, then the scenarios back to back
    initial begin
        repeat (3) @(posedge clk_i);
        #2;
        rst_i = 1'b0;
        run_inherent();
        run_mem_ops();
        run_branches();
        run_bit_ops();
        wrap_up();
    end
endmodule
